/* File: hw/ooe_map.svh */
`ifndef OOE_MAP_SVH
`define OOE_MAP_SVH
// ---------------------------------------------------------------
// clock and register map
// ---------------------------------------------------------------
`define OOE_CLK_HZ 20000000
`define OOE_REG_CTRL 8'h00
`define OOE_REG_FAULT 8'h04
`define OOE_REG_APS 8'h08
`define OOE_REG_PSI 8'h0C
`define OOE_REG_TTI_WR 8'h10
`define OOE_REG_FTFL_WR 8'h14
`define OOE_REG_RX_STAT 8'h18
`define OOE_REG_FLAGS 8'h1C
`define OOE_REG_MFAS 8'h20
// ---------------------------------------------------------------
// reset values
// ---------------------------------------------------------------
`define OOE_CTRL_RST 6'h09
`define OOE_FAULT_RST 16'h0000
`define OOE_APS_RST 32'h00000000
`define OOE_PSI_RST 8'hFE
`define OOE_MFAS_RST 8'hFF
// ---------------------------------------------------------------
// overhead field encodings
// ---------------------------------------------------------------
`define OOE_BEI_MAX 4'h8
`define OOE_BIAE_CODE 4'hB
`define OOE_FI_NONE 8'h00
`define OOE_FI_SF 8'h01
`define OOE_FI_SD 8'h02
`define OOE_PM_NORMAL 3'h1
`define OOE_TCM_NO_SRC 3'h0
`define OOE_TCM_NO_IAE 3'h1
`define OOE_TCM_IAE 3'h2
`define OOE_ST_LCK 3'h5
`define OOE_ST_OCI 3'h6
`define OOE_ST_AIS 3'h7
`define OOE_PT_CBR_LAST 8'h1C
`define OOE_PT_AMP 8'h20
`define OOE_PT_GMP 8'h21
`define OOE_PT_NA1 8'h55
`define OOE_PT_NA2 8'h66
`define OOE_PT_PROP 8'h80
`define OOE_PT_NULL 8'hFD
`define OOE_PT_PRBS 8'hFE
// ---------------------------------------------------------------
// multiframe layout and flag register width
// ---------------------------------------------------------------
`define OOE_TTI_LEN 64
`define OOE_FTFL_LEN 256
`define OOE_FTFL_BWD 8'h80
`define OOE_FLAG_W 6
`endif

/* File: hw/ooe_pkg.sv */
`default_nettype none
package ooe_pkg;
    typedef logic [7:0] ooe_byte_t;
    typedef logic [2:0] ooe_stat_t;
    typedef logic [3:0] ooe_nib_t;
endpackage
`default_nettype wire

/* File: hw/ooe_top.sv */
// What this block does
// - backward defect bit of third byte follows signal fail status
// - tandem status three bits encode source, IAE, LCK, OCI, AIS; 011/100 reserved
// - fault message is two 128-byte fields, forward then backward
// - each fault field holds indication byte, operator id, operator-specific part
// - fault indication 00 none, 01 SF, 02 SD, others reserved
// - operator id starts with three-character country code
// - national carrier code of one to six characters follows country code
// - operator-specific content passes through untouched
// - third byte: error count bits 1-4, defect bit 5, status bits 6-8
// - trail trace is 64 bytes, one per frame, aligned to multiframe count
// - trail trace: source id, destination id, 32-byte operator part
// - backward error field reports parity block errors found by sink
// - error codes 0-8 are counts, 1001-1111 mean zero
// - path status 001 normal, 101 LCK, 110 OCI, 111 AIS; rest reserved
// - protection channel is four bytes, request in first byte
// - protection type sits in bits 5-8 of first byte
// - request codes listed; any other code is reserved
// - payload type byte zero accepts any entered value
// - payload types 01-07 standard mappings, 08-1C further clients
// - 20 marks AMP-only multiplex, 21 marks GMP-capable multiplex
// - FD marks NULL test signal, FE marks PRBS test signal
// - 80 is proprietary; 55, 66, FF not available
// - tandem code 1011 signals backward incoming alignment error
// - multiframe counter steps once per frame, wraps 255 to 0
`timescale 1ns/10ps
`default_nettype none
`include "ooe_map.svh"
module ooe_top
(
    input wire logic clk,                          // 20 MHz clock
    input wire logic reset,                        // sync, active high
    input wire logic ce,                           // clock enable
    input wire logic psel,                         // apb select
    input wire logic penable,                      // apb access phase
    input wire logic pwrite,                       // apb direction
    input wire logic [7:0] paddr,                  // apb byte address
    input wire logic [31:0] pwdata,                // apb write data
    output logic [31:0] prdata,                    // apb read data
    output logic pready,                           // apb ready
    output logic pslverr,                          // apb error
    input wire logic tx_frame,                     // tx frame boundary pulse
    input wire logic sig_fail,                     // local signal fail status
    input wire ooe_pkg::ooe_nib_t bip_err_cnt,     // sink parity block errors
    output ooe_pkg::ooe_byte_t tx_mfas,            // multiframe count
    output ooe_pkg::ooe_byte_t tx_pm_tti,          // path trace byte
    output ooe_pkg::ooe_byte_t tx_pm_b3,           // path third byte
    output ooe_pkg::ooe_byte_t tx_tcm_b3,          // tandem third byte
    output ooe_pkg::ooe_byte_t tx_ftfl,            // fault message byte
    output logic [31:0] tx_aps,                    // protection bytes 1..4
    output ooe_pkg::ooe_byte_t tx_psi,             // payload id byte
    input wire logic rx_frame,                     // rx frame boundary pulse
    input wire ooe_pkg::ooe_byte_t rx_mfas,        // received multiframe count
    input wire ooe_pkg::ooe_byte_t rx_pm_b3,       // received path third byte
    input wire ooe_pkg::ooe_byte_t rx_tcm_b3,      // received tandem third byte
    input wire ooe_pkg::ooe_byte_t rx_ftfl,        // received fault byte
    input wire logic [31:0] rx_aps,                // received protection bytes
    input wire ooe_pkg::ooe_byte_t rx_psi,         // received payload id byte
    output ooe_pkg::ooe_nib_t rx_bei,              // decoded error count
    output logic rx_biae,                          // backward alignment error
    output logic rx_bdi                            // received backward defect
);
    import ooe_pkg::*;

    // all checks run on the one clock and pause in reset
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);

    // ---------------------------------------------------------------
    // decoders
    // ---------------------------------------------------------------
    function automatic logic pm_stat_ok(input ooe_stat_t s);
        pm_stat_ok = (s == `OOE_PM_NORMAL) || (s >= `OOE_ST_LCK);
    endfunction

    function automatic logic tcm_stat_ok(input ooe_stat_t s);
        tcm_stat_ok = (s <= `OOE_TCM_IAE) || (s >= `OOE_ST_LCK);
    endfunction

    function automatic logic aps_req_ok(input ooe_nib_t r);
        // even codes plus 0001 and lockout 1111; odd codes other than 0001 and 1111 reserved
        aps_req_ok = !r[0] || (r == 4'h1) || (r == 4'hF);
    endfunction

    function automatic logic pt_ok(input ooe_byte_t p);
        pt_ok = (p >= 8'h01 && p <= `OOE_PT_CBR_LAST) || p == `OOE_PT_AMP
            || p == `OOE_PT_GMP || p == `OOE_PT_PROP || p == `OOE_PT_NULL
            || p == `OOE_PT_PRBS;
    endfunction

    function automatic logic fi_ok(input ooe_byte_t f);
        fi_ok = (f <= `OOE_FI_SD);
    endfunction

    function automatic ooe_nib_t bei_count(input ooe_nib_t b);
        bei_count = (b <= `OOE_BEI_MAX) ? b : 4'h0;
    endfunction

    // ---------------------------------------------------------------
    // state
    // ---------------------------------------------------------------
    logic [5:0] ctrl_r;
    logic [15:0] fault_r;
    logic [31:0] aps_r;
    ooe_byte_t psi_r;
    ooe_byte_t tti_mem [0:`OOE_TTI_LEN-1];
    ooe_byte_t ftfl_mem [0:`OOE_FTFL_LEN-1];
    logic [`OOE_FLAG_W-1:0] flags_r;
    logic [`OOE_FLAG_W-1:0] flag_set;
    ooe_stat_t rx_pm_stat_r;
    ooe_stat_t rx_tcm_stat_r;
    ooe_nib_t rx_aps_req_r;
    ooe_byte_t rx_pt_r;
    ooe_byte_t rx_fwd_fi_r;
    ooe_byte_t mfas_nxt;
    logic wr_go;
    logic rd_go;
    logic addr_ok;

    assign mfas_nxt = tx_mfas + 8'h01;
    assign wr_go = psel && penable && pready && pwrite;
    assign rd_go = psel && penable && !pready;

    // ---------------------------------------------------------------
    // apb slave: one wait state, data and ready from flops
    // ---------------------------------------------------------------
    always_comb
    begin
        unique case (paddr)
            `OOE_REG_CTRL, `OOE_REG_FAULT, `OOE_REG_APS, `OOE_REG_PSI,
            `OOE_REG_TTI_WR, `OOE_REG_FTFL_WR, `OOE_REG_RX_STAT,
            `OOE_REG_FLAGS, `OOE_REG_MFAS: addr_ok = 1'b1;
            default: addr_ok = 1'b0;
        endcase
    end

    // ready rises one cycle into the access phase, falls after
    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h00000000;
        end
        else if (ce)
        begin
            pready <= rd_go;
            pslverr <= rd_go && !addr_ok;
            if (rd_go && !pwrite)
            begin
                unique case (paddr)
                    `OOE_REG_CTRL: prdata <= {26'h0, ctrl_r};
                    `OOE_REG_FAULT: prdata <= {16'h0000, fault_r};
                    `OOE_REG_APS: prdata <= aps_r;
                    `OOE_REG_PSI: prdata <= {24'h000000, psi_r};
                    `OOE_REG_RX_STAT: prdata <= {rx_fwd_fi_r, rx_pt_r, rx_aps_req_r,
                        1'b0, rx_tcm_stat_r, rx_biae, rx_pm_stat_r, rx_bei};
                    `OOE_REG_FLAGS: prdata <= {26'h0, flags_r};
                    `OOE_REG_MFAS: prdata <= {24'h000000, tx_mfas};
                    default: prdata <= 32'h00000000;
                endcase
            end
            else
            begin
                prdata <= 32'h00000000;
            end
        end
    end

    // ---------------------------------------------------------------
    // configuration registers
    // ---------------------------------------------------------------
    // psi takes any value, no range check on the transmit side
    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            ctrl_r <= `OOE_CTRL_RST;
            fault_r <= `OOE_FAULT_RST;
            aps_r <= `OOE_APS_RST;
            psi_r <= `OOE_PSI_RST;
        end
        else if (ce && wr_go)
        begin
            unique case (paddr)
                `OOE_REG_CTRL: ctrl_r <= pwdata[5:0];
                `OOE_REG_FAULT: fault_r <= pwdata[15:0];
                `OOE_REG_APS: aps_r <= pwdata;
                `OOE_REG_PSI: psi_r <= pwdata[7:0];
                default: ;
            endcase
        end
    end

    // trace and fault memories; software lays out ids and operator parts
    always_ff @(posedge clk)
    begin
        if (ce && wr_go && paddr == `OOE_REG_TTI_WR)
        begin
            tti_mem[pwdata[13:8]] <= pwdata[7:0];
        end
        if (ce && wr_go && paddr == `OOE_REG_FTFL_WR)
        begin
            ftfl_mem[pwdata[15:8]] <= pwdata[7:0];
        end
    end

    // ---------------------------------------------------------------
    // transmit insertion
    // ---------------------------------------------------------------
    // everything changes only on the frame pulse, so a half-written
    // config never straddles a frame
    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            tx_mfas <= `OOE_MFAS_RST;
            tx_pm_tti <= 8'h00;
            tx_pm_b3 <= 8'h00;
            tx_tcm_b3 <= 8'h00;
            tx_ftfl <= 8'h00;
            tx_aps <= 32'h00000000;
            tx_psi <= 8'h00;
        end
        else if (ce && tx_frame)
        begin
            tx_mfas <= mfas_nxt;
            tx_pm_tti <= tti_mem[mfas_nxt[5:0]];
            tx_pm_b3 <= {(bip_err_cnt > `OOE_BEI_MAX) ? `OOE_BEI_MAX : bip_err_cnt,
                sig_fail, ctrl_r[2:0]};
            tx_tcm_b3 <= {(bip_err_cnt > `OOE_BEI_MAX) ? `OOE_BEI_MAX : bip_err_cnt,
                sig_fail, ctrl_r[5:3]};
            if (mfas_nxt == 8'h00)
            begin
                tx_ftfl <= fault_r[7:0];
            end
            else if (mfas_nxt == `OOE_FTFL_BWD)
            begin
                tx_ftfl <= fault_r[15:8];
            end
            else
            begin
                tx_ftfl <= ftfl_mem[mfas_nxt];
            end
            tx_aps <= aps_r;
            tx_psi <= (mfas_nxt == 8'h00) ? psi_r : 8'h00;
        end
    end

    // ---------------------------------------------------------------
    // receive decode
    // ---------------------------------------------------------------
    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            rx_bei <= 4'h0;
            rx_biae <= 1'b0;
            rx_bdi <= 1'b0;
            rx_pm_stat_r <= 3'h0;
            rx_tcm_stat_r <= 3'h0;
            rx_aps_req_r <= 4'h0;
            rx_pt_r <= 8'h00;
            rx_fwd_fi_r <= 8'h00;
        end
        else if (ce && rx_frame)
        begin
            rx_bei <= bei_count(rx_pm_b3[7:4]);
            rx_biae <= (rx_tcm_b3[7:4] == `OOE_BIAE_CODE);
            rx_bdi <= rx_pm_b3[3];
            rx_pm_stat_r <= rx_pm_b3[2:0];
            rx_tcm_stat_r <= rx_tcm_b3[2:0];
            rx_aps_req_r <= rx_aps[31:28];
            if (rx_mfas == 8'h00)
            begin
                rx_pt_r <= rx_psi;
                rx_fwd_fi_r <= rx_ftfl;
            end
        end
    end

    // reserved-code events; flags are sticky until software writes one
    always_comb
    begin
        flag_set = '0;
        if (rx_frame)
        begin
            flag_set[0] = !pm_stat_ok(rx_pm_b3[2:0]);
            flag_set[1] = !tcm_stat_ok(rx_tcm_b3[2:0]);
            flag_set[2] = !aps_req_ok(rx_aps[31:28]);
            flag_set[3] = (rx_mfas == 8'h00) && !pt_ok(rx_psi);
            flag_set[4] = (rx_mfas == 8'h00) && !fi_ok(rx_ftfl);
            flag_set[5] = (rx_mfas == `OOE_FTFL_BWD) && !fi_ok(rx_ftfl);
        end
    end

    // a set in the clearing cycle survives
    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            flags_r <= '0;
        end
        else if (ce)
        begin
            if (wr_go && paddr == `OOE_REG_FLAGS)
            begin
                flags_r <= (flags_r & ~pwdata[`OOE_FLAG_W-1:0]) | flag_set;
            end
            else
            begin
                flags_r <= flags_r | flag_set;
            end
        end
    end

    // ---------------------------------------------------------------
    // assertions
    // ---------------------------------------------------------------
    property p_bdi;
        ce && tx_frame |=> tx_pm_b3[3] == $past(sig_fail) && tx_tcm_b3[3] == $past(sig_fail);
    endproperty
    a_bdi: assert property (p_bdi) else $error("bdi not following fail");

    property p_mfas_step;
        ce && tx_frame |=> tx_mfas == 8'($past(tx_mfas) + 8'h01);
    endproperty
    a_mfas_step: assert property (p_mfas_step) else $error("mfas not stepping");

    property p_hold;
        !(ce && tx_frame) |=> $stable(tx_pm_b3) && $stable(tx_aps) && $stable(tx_mfas);
    endproperty
    a_hold: assert property (p_hold) else $error("tx field moved mid frame");

    property p_bei_range;
        rx_bei <= `OOE_BEI_MAX;
    endproperty
    a_bei_range: assert property (p_bei_range) else $error("bei count above 8");

    property p_biae;
        ce && rx_frame |=> rx_biae == ($past(rx_tcm_b3[7:4]) == 4'hB);
    endproperty
    a_biae: assert property (p_biae) else $error("biae decode wrong");

    property p_aps_flag;
        ce && rx_frame && rx_aps[31:28] == 4'h3 |=> flags_r[2];
    endproperty
    a_aps_flag: assert property (p_aps_flag) else $error("reserved request missed");

    property p_pt_flag;
        ce && rx_frame && rx_mfas == 8'h00 && (rx_psi == 8'h55 || rx_psi == 8'hFF)
            |=> flags_r[3];
    endproperty
    a_pt_flag: assert property (p_pt_flag) else $error("unavailable type missed");

    property p_pt_good;
        ce && rx_frame && rx_mfas == 8'h00 && rx_psi == 8'h21 && !flags_r[3]
            && !wr_go |=> !flags_r[3];
    endproperty
    a_pt_good: assert property (p_pt_good) else $error("gmp type flagged");

    property p_stat_flag;
        ce && rx_frame && rx_pm_b3[2:0] == 3'h0 |=> flags_r[0];
    endproperty
    a_stat_flag: assert property (p_stat_flag) else $error("reserved status missed");

    property p_fi_flag;
        ce && rx_frame && rx_mfas == 8'h80 && rx_ftfl == 8'h03 |=> flags_r[5];
    endproperty
    a_fi_flag: assert property (p_fi_flag) else $error("reserved fault byte missed");

    property p_psi_slot;
        ce && tx_frame ##1 tx_mfas != 8'h00 |-> tx_psi == 8'h00;
    endproperty
    a_psi_slot: assert property (p_psi_slot) else $error("psi outside slot 0");

    property p_apb_ready;
        psel && penable && !pready && ce |=> pready ##1 !pready;
    endproperty
    a_apb_ready: assert property (p_apb_ready) else $error("apb ready timing");

    c_wrap: cover property (ce && tx_frame && tx_mfas == 8'hFF);
    c_ftfl_bwd: cover property (ce && tx_frame && mfas_nxt == 8'h80);
    c_biae: cover property (rx_biae);
    c_flag_clear: cover property (wr_go && paddr == 8'h1C && flags_r != '0);

endmodule
`default_nettype wire

/* File: tb/ooe_far_end.sv */
`timescale 1ns/10ps
`default_nettype none
// ----------------------------------------------------------------
// remote element: sends one overhead set per received frame
// ----------------------------------------------------------------
module ooe_far_end
(
    input wire logic clk,                  // shared frame clock
    output logic rx_frame,                 // frame boundary pulse
    output ooe_pkg::ooe_byte_t rx_mfas,    // multiframe count
    output ooe_pkg::ooe_byte_t rx_pm_b3,   // path third byte
    output ooe_pkg::ooe_byte_t rx_tcm_b3,  // tandem third byte
    output ooe_pkg::ooe_byte_t rx_ftfl,    // fault byte
    output logic [31:0] rx_aps,            // protection bytes
    output ooe_pkg::ooe_byte_t rx_psi      // payload id byte
);
    import ooe_pkg::*;

    // idle lines at time zero
    initial
    begin
        rx_frame = 1'b0;
        rx_mfas = 8'h00;
        rx_pm_b3 = 8'h00;
        rx_tcm_b3 = 8'h00;
        rx_ftfl = 8'h00;
        rx_aps = 32'h00000000;
        rx_psi = 8'h00;
    end

    // one frame at multiframe count mf; fields only valid with the pulse, so
    // they are inverted afterwards to catch sampling outside the frame
    task send(input ooe_nib_t bei, input logic bdi, input ooe_stat_t st, input ooe_nib_t req,
              input ooe_byte_t pt, input ooe_byte_t fi, input ooe_byte_t mf);
        @(posedge clk);
        rx_frame <= 1'b1;
        rx_mfas <= mf;
        rx_pm_b3 <= {bei, bdi, st};
        rx_tcm_b3 <= {bei, 1'b0, st};
        rx_aps <= {req, 4'h2, 24'h00A5A5};
        rx_psi <= pt;
        rx_ftfl <= fi;
        @(posedge clk);
        rx_frame <= 1'b0;
        rx_mfas <= ~rx_mfas;
        rx_pm_b3 <= ~rx_pm_b3;
        rx_tcm_b3 <= ~rx_tcm_b3;
        rx_aps <= ~rx_aps;
        rx_psi <= ~rx_psi;
        rx_ftfl <= ~rx_ftfl;
        #1;
    endtask
endmodule
`default_nettype wire

/* File: tb/ooe_top_tb.sv */
`timescale 1ns/10ps
`default_nettype none
`include "ooe_map.svh"
module ooe_top_tb;
    import ooe_pkg::*;
    logic clk = 1'b0, reset = 1'b1, ce = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, tx_aps, rx_aps, q;
    logic pready, pslverr, tx_frame = 1'b0, sig_fail = 1'b0, rx_frame, rx_biae, rx_bdi, er;
    ooe_nib_t bip_err_cnt = 4'h0, rx_bei;
    ooe_byte_t tx_mfas, tx_pm_tti, tx_pm_b3, tx_tcm_b3, tx_ftfl, tx_psi, mf = 8'hFF;
    ooe_byte_t rx_mfas, rx_pm_b3, rx_tcm_b3, rx_ftfl, rx_psi, pt;
    ooe_stat_t st;
    ooe_nib_t c;
    logic [15:0] pt_unk_mask = 16'h8E40;
    ooe_byte_t pt_tab [16] = '{8'h01, 8'h02, 8'h05, 8'h07, 8'h08, 8'h1C, 8'h1D, 8'h20,
                               8'h21, 8'h22, 8'h55, 8'h66, 8'h80, 8'hFD, 8'hFE, 8'hFF};
    int err_total = 0, total_checks = 0;

    // ------------------------------------------------------------
    // clock, design and far end
    // ------------------------------------------------------------
    always #25 clk = ~clk;
    ooe_top u_dut (.clk(clk), .reset(reset), .ce(ce), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .tx_frame(tx_frame), .sig_fail(sig_fail),
        .bip_err_cnt(bip_err_cnt), .tx_mfas(tx_mfas), .tx_pm_tti(tx_pm_tti),
        .tx_pm_b3(tx_pm_b3), .tx_tcm_b3(tx_tcm_b3), .tx_ftfl(tx_ftfl), .tx_aps(tx_aps),
        .tx_psi(tx_psi), .rx_frame(rx_frame), .rx_mfas(rx_mfas), .rx_pm_b3(rx_pm_b3),
        .rx_tcm_b3(rx_tcm_b3), .rx_ftfl(rx_ftfl), .rx_aps(rx_aps), .rx_psi(rx_psi),
        .rx_bei(rx_bei), .rx_biae(rx_biae), .rx_bdi(rx_bdi));
    ooe_far_end u_far (.clk(clk), .rx_frame(rx_frame), .rx_mfas(rx_mfas),
        .rx_pm_b3(rx_pm_b3), .rx_tcm_b3(rx_tcm_b3), .rx_ftfl(rx_ftfl), .rx_aps(rx_aps),
        .rx_psi(rx_psi));

    // ------------------------------------------------------------
    // shared tasks
    // ------------------------------------------------------------
    task chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            err_total++;
            $display("BAD %s exp %h seen %h", what, exp, seen);
        end
    endtask

    // apb transfer; request held until pready is sampled high
    task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        // no limit here: only the watchdog ends a stuck wait
        do
        begin
            @(posedge clk);
            n++;
        end
        while (pready !== 1'b1);
        q = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        chk("apb wait", 32'(n), 32'h2);
    endtask

    // one transmitted frame; the bench keeps its own multiframe count
    task frame;
        @(posedge clk);
        tx_frame <= 1'b1;
        @(posedge clk);
        tx_frame <= 1'b0;
        #1;
        if (ce) mf = mf + 8'h01;
        chk("tx_mfas", 32'(tx_mfas), 32'(mf));
    endtask

    task tally_and_finish;
        $display("checks %0d mismatches %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    // watchdog far beyond the roughly 800 cycles of the sequence
    initial
    begin
        #400000;
        err_total++;
        tally_and_finish();
    end

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial
    begin
        repeat (2) @(posedge clk);
        reset <= 1'b0;
        #1;
        chk("mfas reset", 32'(tx_mfas), 32'hFF);
        apb(1'b0, `OOE_REG_CTRL, 32'h0);
        chk("ctrl reset", q, 32'h09);
        apb(1'b0, `OOE_REG_PSI, 32'h0);
        chk("psi reset", q, 32'hFE);
        apb(1'b0, 8'h24, 32'h0);
        chk("unmapped err", {31'h0, er}, 32'h1);
        // configure tx overhead, then a frozen frame with ce low
        apb(1'b1, `OOE_REG_CTRL, 32'h3D);
        apb(1'b1, `OOE_REG_FAULT, 32'h0201);
        apb(1'b1, `OOE_REG_APS, 32'hE5A1B2C3);
        apb(1'b1, `OOE_REG_PSI, 32'h21);
        apb(1'b1, `OOE_REG_TTI_WR, 32'h015A);
        apb(1'b1, `OOE_REG_FTFL_WR, 32'h02C3);
        apb(1'b1, `OOE_REG_FTFL_WR, 32'h00EE);
        sig_fail <= 1'b1;
        bip_err_cnt <= 4'hC;
        ce <= 1'b0;
        frame();
        @(posedge clk);
        ce <= 1'b1;
        frame();
        chk("pm b3", 32'(tx_pm_b3), 32'h8D);
        chk("tcm b3", 32'(tx_tcm_b3), 32'h8F);
        chk("aps", tx_aps, 32'hE5A1B2C3);
        chk("psi", 32'(tx_psi), 32'h21);
        chk("ftfl fwd", 32'(tx_ftfl), 32'h01);
        // a mid-frame change must wait for the next boundary
        sig_fail <= 1'b0;
        bip_err_cnt <= 4'h3;
        apb(1'b1, `OOE_REG_CTRL, 32'h09);
        chk("pm b3 held", 32'(tx_pm_b3), 32'h8D);
        frame();
        chk("pm b3 new", 32'(tx_pm_b3), 32'h31);
        chk("tcm b3 new", 32'(tx_tcm_b3), 32'h31);
        chk("tti 1", 32'(tx_pm_tti), 32'h5A);
        frame();
        chk("ftfl opr", 32'(tx_ftfl), 32'hC3);
        repeat (63) frame();
        chk("tti 65", 32'(tx_pm_tti), 32'h5A);
        repeat (63) frame();
        chk("ftfl bwd", 32'(tx_ftfl), 32'h02);
        repeat (128) frame();
        chk("ftfl wrap", 32'(tx_ftfl), 32'h01);
        apb(1'b0, `OOE_REG_MFAS, 32'h0);
        chk("mfas reg", q, 32'(mf));
        // receive side: every nibble, status and request code
        for (int i = 0; i < 16; i++)
        begin
            c = 4'(i);
            st = c[2:0];
            pt = pt_tab[i];
            u_far.send(c, c[0], st, c, pt, 8'(i), 8'h00);
            chk("rx bei", 32'(rx_bei), (i <= 8) ? 32'(i) : 32'h0);
            chk("rx biae", 32'(rx_biae), 32'(i == 11));
            chk("rx bdi", 32'(rx_bdi), 32'(c[0]));
            apb(1'b0, `OOE_REG_RX_STAT, 32'h0);
            chk("rx stat", q, {8'(i), pt, c, 1'b0, st, i == 11, st,
                (i <= 8) ? c : 4'h0});
            apb(1'b0, `OOE_REG_FLAGS, 32'h0);
            chk("flags", q, {26'h0, 1'b0, i >= 3, pt_unk_mask[i], c[0] && c != 1 && c != 15,
                st == 3 || st == 4, st == 0 || st == 2 || st == 3 || st == 4});
            apb(1'b1, `OOE_REG_FLAGS, 32'h3F);
        end
        // slot 128 judges the backward byte and leaves pt and fwd byte alone
        u_far.send(4'h1, 1'b0, 3'h1, 4'h0, 8'h21, 8'h03, `OOE_FTFL_BWD);
        apb(1'b0, `OOE_REG_RX_STAT, 32'h0);
        chk("rx stat 128", q, 32'h0FFF0111);
        apb(1'b0, `OOE_REG_FLAGS, 32'h0);
        chk("flags 128", q, 32'h20);
        apb(1'b1, `OOE_REG_FLAGS, 32'h3F);
        apb(1'b0, `OOE_REG_FLAGS, 32'h0);
        chk("flags clear", q, 32'h0);
        tally_and_finish();
    end
endmodule
`default_nettype wire
